/* File: src/upec_params.svh */
// Summary of operation
// [R01] Parity-enable adds parity on send and checks it on receive, 7/8-bit async only.
// [R02] Parity-sense 0 gives odd parity, 1 gives even, both directions.
// [R03] Buffer write computes parity into data bit 7 (7-bit) or ninth bit (8-bit).
// [R04] Software sets parity controls before writing transmit data.
// [R05] After buffer transfer, received parity is checked; mismatch sets the parity flag.
// [R06] Complete new word while buffer still unread sets the overrun flag.
// [R07] Only data buffer reads free the buffer; ninth-bit reads never matter.
// [R08] On overrun software reads, disables reception, rereads, re-enables, asks resend.
// [R09] Stop bit sampled three times at centre; majority zero sets framing flag.
// [R10] Reading control register clears all three error flags; they are read-only.
// [R11] Software reads the parity flag only from the receive interrupt.
// [R12] Software avoids read-modify-write or bit tests on the control register.
// [R13] Receive interrupt at ninth-bit centre for 9-bit/8+parity, else stop centre.
// [R14] Overrun timed like receive interrupt; framing at stop; parity at transfer.
// [R15] In 9-bit/8+parity, handler waits one bit before checking framing.
// [R16] Async transmit interrupt is raised just before the stop bit starts.
// [R17] Shift-mode transmit interrupt right after last bit or last selected edge.
// [R18] Shift-mode receive interrupt when word moves into buffer after last clock.
// [R19] Format 00 shift,01 7-bit,10 8-bit,11 9-bit; clock 00 timer..11 external.
// [R20] Edge-select 0 uses rising shift-clock edge, 1 the falling edge.
// [R21] Software never picks baud generator clock when prescaler runs at fc/16.
// [R22] Mode register has handshake, receive and wakeup enables, active high.
// [R23] Direction 0 drives shift clock from baud generator halved; 1 takes input.
// [R24] 9-bit with wakeup raises receive interrupt only when ninth bit is 1.
// [R25] Writes to control read-only fields are ignored.
`ifndef UPEC_PARAMS_SVH
`define UPEC_PARAMS_SVH
`define UPEC_ADDR_W 12
`define UPEC_IDX_BUF 10'h200
`define UPEC_IDX_CTRL 10'h201
`define UPEC_IDX_MODE 10'h202
`define UPEC_CTRL_RESET 8'h00
`define UPEC_MODE_RESET 8'h00
`define UPEC_C_NINTH 7
`define UPEC_C_EVEN 6
`define UPEC_C_PE 5
`define UPEC_C_OVR 4
`define UPEC_C_PAR 3
`define UPEC_C_FRM 2
`define UPEC_C_EDGE 1
`define UPEC_C_DIR 0
`define UPEC_C_WMASK 8'h63
`define UPEC_M_TB8 7
`define UPEC_M_HS 6
`define UPEC_M_RXE 5
`define UPEC_M_WU 4
`define UPEC_M_FMT 3:2
`define UPEC_M_CLK 1:0
`define UPEC_TICK_LAST 4'hf
`define UPEC_SMP_A 4'h7
`define UPEC_SMP_B 4'h8
`define UPEC_SMP_C 4'h9
`define UPEC_IO_BITS 4'h8
`endif

/* File: src/upec_pkg.sv */
package upec_pkg;
    typedef enum logic [1:0] {fmt_io, fmt_7, fmt_8, fmt_9} upec_fmt_e;
    typedef enum logic [1:0] {clk_timer, clk_baud, clk_sys, clk_ext} upec_clk_e;
    typedef enum logic [1:0] {rx_idle, rx_start, rx_data, rx_stop} upec_rx_e;
    typedef enum logic [2:0] {tx_idle, tx_start, tx_data, tx_stop, tx_shift} upec_tx_e;
    typedef logic [3:0] upec_nbits_t;
    typedef logic [8:0] upec_word_t;
endpackage

/* File: src/upec_tx.sv */
`include "upec_params.svh"
module upec_tx (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_uart,
    input wire logic i_bit_tick,
    input wire logic i_io_edge,
    input wire logic i_cts_ok,
    input wire logic i_load,
    input wire upec_pkg::upec_word_t i_word,
    input wire upec_pkg::upec_nbits_t i_nbits,
    output logic o_line,
    output logic o_irq,
    output logic o_busy
);
    import upec_pkg::*;

    upec_tx_e st, next_st;
    logic [3:0] cnt, next_cnt;
    upec_nbits_t idx, next_idx, nb, next_nb;
    upec_word_t hold, next_hold, sh, next_sh;
    logic full, next_full, next_line, next_irq;

    // Bit boundary of the transmit bit clock: one bit per sixteen ticks
    logic bnd;
    assign bnd = i_bit_tick && cnt == `UPEC_TICK_LAST;

    always_comb begin
        next_st = st;
        next_cnt = i_bit_tick ? 4'(cnt + 4'h1) : cnt;
        next_idx = idx;
        next_nb = nb;
        next_hold = hold;
        next_sh = sh;
        next_full = full;
        next_line = o_line;
        next_irq = 1'b0;
        if (i_load) begin
            next_hold = i_word;
            next_nb = i_uart ? i_nbits : `UPEC_IO_BITS;
            next_full = 1'b1;
        end
        case (st)
            tx_idle: begin
                if (full && !i_uart) begin
                    next_line = hold[0];
                    next_sh = 9'(hold >> 1);
                    next_idx = 4'h0;
                    next_full = i_load;
                    next_st = tx_shift;
                end else if (full && bnd && i_cts_ok) begin
                    next_line = 1'b0;
                    next_sh = hold;
                    next_full = i_load;
                    next_st = tx_start;
                end
            end
            tx_start: begin
                if (bnd) begin
                    next_line = sh[0];
                    next_sh = 9'(sh >> 1);
                    next_idx = 4'h0;
                    next_st = tx_data;
                end
            end
            tx_data: begin
                if (bnd && idx == 4'(nb - 4'h1)) begin
                    next_line = 1'b1;
                    next_irq = 1'b1; // R16
                    next_st = tx_stop;
                end else if (bnd) begin
                    next_line = sh[0];
                    next_sh = 9'(sh >> 1);
                    next_idx = 4'(idx + 4'h1);
                end
            end
            tx_stop: begin
                if (bnd) begin
                    next_st = tx_idle;
                end
            end
            tx_shift: begin
                if (i_io_edge && idx == 4'(nb - 4'h1)) begin
                    next_line = 1'b1;
                    next_irq = 1'b1; // R17
                    next_st = tx_idle;
                end else if (i_io_edge) begin
                    next_line = sh[0];
                    next_sh = 9'(sh >> 1);
                    next_idx = 4'(idx + 4'h1);
                end
            end
            default: next_st = tx_idle;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st <= tx_idle;
            cnt <= 4'h0;
            idx <= 4'h0;
            nb <= `UPEC_IO_BITS;
            hold <= 9'h000;
            sh <= 9'h000;
            full <= 1'b0;
            o_line <= 1'b1;
            o_irq <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            idx <= next_idx;
            nb <= next_nb;
            hold <= next_hold;
            sh <= next_sh;
            full <= next_full;
            o_line <= next_line;
            o_irq <= next_irq;
            o_busy <= next_full || next_st != tx_idle;
        end
    end
endmodule

/* File: src/upec_channel.sv */
// Our own choice: the Avalon-MM register port.
`include "upec_params.svh"
module upec_channel (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic [`UPEC_ADDR_W-1:0] i_avs_address,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_baud_tick,
    input wire logic i_timer_tick,
    input wire logic i_rx_line,
    input wire logic i_clear_to_send_n,
    input wire logic i_shift_clock_pin,
    output logic o_shift_clock_pin,
    output logic o_shift_clock_oe,
    output logic o_tx_line,
    output logic o_rx_interrupt,
    output logic o_tx_interrupt
);
    import upec_pkg::*;

    function automatic logic hit(input logic [`UPEC_ADDR_W-1:0] a, input logic [9:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // Parity bit that makes the total even (even=1) or odd (even=0)
    function automatic logic par_of(input logic [7:0] d, input logic even);
        return even ? ^d : ~^d; // R02
    endfunction

    function automatic upec_nbits_t frame_bits(input upec_fmt_e f, input logic pe);
        case (f)
            fmt_7: return pe ? 4'h8 : 4'h7; // R01
            fmt_8: return pe ? 4'h9 : 4'h8; // R01
            fmt_9: return 4'h9;
            default: return `UPEC_IO_BITS;
        endcase
    endfunction

    logic [7:0] ctrl, next_ctrl, mode, next_mode, data_buffer, next_data_buffer;
    logic buf_full, next_buf_full, ack, next_ack;
    logic [31:0] next_rdata;
    logic tx_load, next_tx_load;
    upec_word_t tx_word, next_tx_word;
    logic next_rx_irq;

    upec_fmt_e fmt;
    upec_clk_e csel;
    logic even, pe, edge_sel, dir, io_mode;
    upec_nbits_t nb;
    assign fmt = upec_fmt_e'(mode[`UPEC_M_FMT]); // R19
    assign csel = upec_clk_e'(mode[`UPEC_M_CLK]); // R19
    assign even = ctrl[`UPEC_C_EVEN];
    assign pe = ctrl[`UPEC_C_PE];
    assign edge_sel = ctrl[`UPEC_C_EDGE];
    assign dir = ctrl[`UPEC_C_DIR];
    assign io_mode = fmt == fmt_io;
    assign nb = frame_bits(fmt, pe);

    // Bus access: one wait state, the side effect happens once at the ack edge
    logic acc, rd_buf, rd_ctrl, wr_buf, wr_ctrl, wr_mode, wr_ok;
    assign acc = (i_avs_read || i_avs_write) && !ack;
    assign wr_ok = acc && i_avs_write && i_avs_byteenable[0];
    assign rd_buf = acc && i_avs_read && hit(i_avs_address, `UPEC_IDX_BUF);
    assign rd_ctrl = acc && i_avs_read && hit(i_avs_address, `UPEC_IDX_CTRL);
    assign wr_buf = wr_ok && hit(i_avs_address, `UPEC_IDX_BUF);
    assign wr_ctrl = wr_ok && hit(i_avs_address, `UPEC_IDX_CTRL);
    assign wr_mode = wr_ok && hit(i_avs_address, `UPEC_IDX_MODE);

    // Shift clock: driven from halved baud ticks, or taken from the pin
    logic sclk_int, next_sclk_int, sclk_prev, clk_now, rise, fall, io_edge, sio_tick;
    logic tx_busy, next_clk_oe;
    assign clk_now = (io_mode && !dir) ? sclk_int : i_shift_clock_pin; // R23
    assign rise = clk_now && !sclk_prev;
    assign fall = !clk_now && sclk_prev;
    assign io_edge = io_mode && (edge_sel ? fall : rise); // R20

    always_comb begin
        case (csel)
            clk_timer: sio_tick = i_timer_tick; // R19
            clk_baud: sio_tick = i_baud_tick;
            clk_sys: sio_tick = 1'b1;
            default: sio_tick = rise;
        endcase
    end

    always_comb begin
        next_sclk_int = 1'b1;
        // Idles high; runs only while there is something to shift
        if (io_mode && !dir && (tx_busy || (mode[`UPEC_M_RXE] && !buf_full))) begin
            // Hold high in the cycle after a rise: busy drops one cycle late and
            // would otherwise give a finished word a ninth pulse
            next_sclk_int = (i_baud_tick && !rise) ? !sclk_int : sclk_int; // R23
        end
        next_clk_oe = io_mode && !dir; // R23
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sclk_int <= 1'b1;
            sclk_prev <= 1'b1;
            o_shift_clock_oe <= 1'b0;
        end else begin
            sclk_int <= next_sclk_int;
            sclk_prev <= clk_now;
            o_shift_clock_oe <= next_clk_oe;
        end
    end
    assign o_shift_clock_pin = sclk_int;

    // Receiver: three samples per bit, majority decides; shift mode takes one sample per selected edge
    upec_rx_e rx_st, next_rx_st;
    logic [3:0] cnt, next_cnt;
    upec_nbits_t idx, next_idx;
    logic [1:0] smp, next_smp;
    upec_word_t rx_sh, next_rx_sh, rx_word;
    logic maj, mid, xfer, frm_set;
    assign maj = (smp[0] && smp[1]) || (smp[0] && i_rx_line) || (smp[1] && i_rx_line);
    assign mid = sio_tick && cnt == `UPEC_SMP_C;
    assign rx_word = 9'(next_rx_sh >> 4'(4'h9 - nb));

    always_comb begin
        next_rx_st = rx_st;
        next_cnt = cnt;
        next_idx = idx;
        next_smp = smp;
        next_rx_sh = rx_sh;
        xfer = 1'b0;
        frm_set = 1'b0;
        if (!mode[`UPEC_M_RXE]) begin
            next_rx_st = rx_idle; // R22
            next_idx = 4'h0;
        end else if (io_mode) begin
            if (io_edge) begin
                next_rx_sh = {i_rx_line, rx_sh[8:1]};
                next_idx = 4'(idx + 4'h1);
                if (idx == 4'(`UPEC_IO_BITS - 4'h1)) begin
                    xfer = 1'b1; // R18
                    next_idx = 4'h0;
                end
            end
        end else if (sio_tick) begin
            next_cnt = 4'(cnt + 4'h1);
            if (cnt == `UPEC_SMP_A) next_smp[0] = i_rx_line;
            if (cnt == `UPEC_SMP_B) next_smp[1] = i_rx_line;
            case (rx_st)
                rx_idle: begin
                    if (!i_rx_line) begin
                        next_rx_st = rx_start;
                        next_cnt = 4'h1;
                    end
                end
                rx_start: begin
                    if (mid) begin
                        next_rx_st = maj ? rx_idle : rx_data;
                        next_idx = 4'h0;
                    end
                end
                rx_data: begin
                    if (mid) begin
                        next_rx_sh = {maj, rx_sh[8:1]};
                        next_idx = 4'(idx + 4'h1);
                        if (idx == 4'(nb - 4'h1)) begin
                            next_rx_st = rx_stop;
                            xfer = nb == 4'h9; // R13 R14
                        end
                    end
                end
                rx_stop: begin
                    if (mid) begin
                        next_rx_st = rx_idle;
                        frm_set = !maj; // R09 R14
                        xfer = nb != 4'h9; // R13 R14
                    end
                end
                default: next_rx_st = rx_idle;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rx_st <= rx_idle;
            cnt <= 4'h0;
            idx <= 4'h0;
            smp <= 2'b11;
            rx_sh <= 9'h000;
        end else begin
            rx_st <= next_rx_st;
            cnt <= next_cnt;
            idx <= next_idx;
            smp <= next_smp;
            rx_sh <= next_rx_sh;
        end
    end

    // Registers; hardware sets come last so they win over a same-cycle clear
    logic [7:0] wd;
    logic par_bad;
    assign par_bad = pe && ((fmt == fmt_7 && par_of({1'b0, rx_word[6:0]}, even) != rx_word[7])
        || (fmt == fmt_8 && par_of(rx_word[7:0], even) != rx_word[8])); // R05

    always_comb begin
        next_ctrl = ctrl;
        next_mode = mode;
        next_data_buffer = data_buffer;
        next_buf_full = buf_full;
        next_tx_load = 1'b0;
        next_tx_word = tx_word;
        next_rx_irq = 1'b0;
        next_ack = acc;
        wd = i_avs_writedata[7:0];
        next_rdata = 32'h0;
        if (acc && i_avs_read) begin
            if (hit(i_avs_address, `UPEC_IDX_BUF)) next_rdata = {24'h0, data_buffer};
            else if (hit(i_avs_address, `UPEC_IDX_CTRL)) next_rdata = {24'h0, ctrl};
            else if (hit(i_avs_address, `UPEC_IDX_MODE)) next_rdata = {24'h0, mode};
        end
        if (wr_ctrl) begin
            next_ctrl = (ctrl & ~`UPEC_C_WMASK) | (wd & `UPEC_C_WMASK); // R25
        end
        if (wr_mode) next_mode = wd; // R22
        if (rd_ctrl) begin
            next_ctrl[`UPEC_C_OVR] = 1'b0; // R10
            next_ctrl[`UPEC_C_PAR] = 1'b0; // R10
            next_ctrl[`UPEC_C_FRM] = 1'b0; // R10
        end
        if (rd_buf) next_buf_full = 1'b0; // R07
        if (wr_buf) begin
            if (pe && fmt == fmt_7) wd[7] = par_of({1'b0, wd[6:0]}, even); // R03
            if (pe && fmt == fmt_8) next_mode[`UPEC_M_TB8] = par_of(wd, even); // R03
            next_tx_word = {next_mode[`UPEC_M_TB8], wd};
            next_tx_load = 1'b1;
        end
        if (frm_set) next_ctrl[`UPEC_C_FRM] = 1'b1; // R09
        if (xfer) begin
            // A buffer read at this edge takes the old word, so the new one fits
            if (buf_full && !rd_buf) begin
                next_ctrl[`UPEC_C_OVR] = 1'b1; // R06
            end else begin
                next_data_buffer = rx_word[7:0];
                next_buf_full = 1'b1;
                if (fmt == fmt_8 || fmt == fmt_9) next_ctrl[`UPEC_C_NINTH] = rx_word[8];
                if (par_bad) next_ctrl[`UPEC_C_PAR] = 1'b1; // R05
            end
            next_rx_irq = !(fmt == fmt_9 && mode[`UPEC_M_WU] && !rx_word[8]); // R24 R13
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl <= `UPEC_CTRL_RESET;
            mode <= `UPEC_MODE_RESET;
            data_buffer <= 8'h00;
            buf_full <= 1'b0;
            ack <= 1'b0;
            o_avs_readdata <= 32'h0;
            o_avs_waitrequest <= 1'b1;
            tx_load <= 1'b0;
            tx_word <= 9'h000;
            o_rx_interrupt <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            mode <= next_mode;
            data_buffer <= next_data_buffer;
            buf_full <= next_buf_full;
            ack <= next_ack;
            o_avs_readdata <= next_rdata;
            o_avs_waitrequest <= !next_ack;
            tx_load <= next_tx_load;
            tx_word <= next_tx_word;
            o_rx_interrupt <= next_rx_irq;
        end
    end

    upec_tx u_tx (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_uart(!io_mode),
        .i_bit_tick(sio_tick),
        .i_io_edge(io_edge),
        .i_cts_ok(!mode[`UPEC_M_HS] || !i_clear_to_send_n), // R22
        .i_load(tx_load),
        .i_word(tx_word),
        .i_nbits(nb),
        .o_line(o_tx_line),
        .o_irq(o_tx_interrupt),
        .o_busy(tx_busy)
    );

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    chk_err_clear: assert property ( // R10
        rd_ctrl && !xfer && !frm_set |=> !ctrl[4] && !ctrl[3] && !ctrl[2])
        else $error("error flags not cleared by control read");
    chk_overrun_set: assert property ( // R06
        xfer && buf_full && !rd_buf |=> ctrl[`UPEC_C_OVR] && $stable(data_buffer))
        else $error("overrun not flagged or buffer overwritten");
    chk_ro_fields: assert property ( // R25
        wr_ctrl && !xfer && !frm_set |=> $stable(ctrl[7:2] & 6'h27))
        else $error("read-only control field changed by write");
    chk_wake_gate: assert property ( // R24
        xfer && fmt == fmt_9 && mode[`UPEC_M_WU] && !rx_word[8] |=> !o_rx_interrupt)
        else $error("receive interrupt despite wakeup filter");
    chk_rx_irq: assert property ( // R13
        xfer && fmt != fmt_9 |=> o_rx_interrupt && buf_full)
        else $error("receive interrupt missing at transfer");
    chk_tx_par7: assert property ( // R03
        wr_buf && pe && fmt == fmt_7 |=> tx_load && ^tx_word[7:0] == !even)
        else $error("7-bit transmit parity wrong");
    chk_tx_par8: assert property ( // R03
        wr_buf && pe && fmt == fmt_8 |=> ^{mode[`UPEC_M_TB8], tx_word[7:0]} == !even)
        else $error("8-bit transmit parity wrong");
    chk_frame_err: assert property ( // R09
        frm_set |=> ctrl[`UPEC_C_FRM])
        else $error("framing error not flagged");
    chk_parity_err: assert property ( // R05
        xfer && !buf_full && par_bad |=> ctrl[`UPEC_C_PAR] ##1 ctrl[`UPEC_C_PAR] || $past(rd_ctrl))
        else $error("parity error not flagged");
endmodule

/* File: testbench/upec_peer.sv */
module upec_peer (
    input wire logic i_clk,
    input wire logic i_sck,
    input wire logic i_tx_line,
    output logic o_rx_line
);
    timeunit 1ns;
    timeprecision 1ns;
    time t_rx;
    time t_tx;
    logic [7:0] sr = 8'h00;
    int n_sck = 0;
    initial o_rx_line = 1'b1;
    // Far-end shift register: takes the transmit line on each rising shift clock
    always @(posedge i_sck) begin
        sr = {i_tx_line, sr[7:1]};
        n_sck++;
    end
    // A bit lasts 16 ticks; the system-clock source ticks every cycle
    task automatic send(input logic [8:0] bits, input int n, input logic stop);
        @(posedge i_clk);
        t_rx = $time;
        o_rx_line <= 1'b0;
        repeat (16) @(posedge i_clk);
        for (int i = 0; i < n; i++) begin
            o_rx_line <= bits[i];
            repeat (16) @(posedge i_clk);
        end
        o_rx_line <= stop;
        repeat (16) @(posedge i_clk);
        // Pulled-up line returns to idle high once the frame is over
        o_rx_line <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask
    task automatic grab(input int n, output logic [9:0] bits);
        int w;
        w = 0;
        bits = '0;
        while (i_tx_line === 1'b1 && w < 400) begin
            @(posedge i_clk);
            w++;
        end
        t_tx = $time;
        repeat (8) @(posedge i_clk);
        for (int i = 0; i <= n; i++) begin
            repeat (16) @(posedge i_clk);
            bits[i] = i_tx_line;
        end
    endtask
endmodule

/* File: testbench/upec_channel_test.sv */
`include "upec_params.svh"
module upec_channel_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] adr = '0;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic [31:0] v;
    logic wait_r;
    logic rx_line;
    logic tx_line;
    logic rx_irq;
    logic tx_irq;
    logic sck;
    logic sck_oe;
    logic baud = 1'b0;
    logic cts_n = 1'b0;
    logic [9:0] got;
    int mismatches = 0;
    int check_count = 0;
    int rx_cnt = 0;
    int tx_cnt = 0;
    time t_rirq;
    time t_tirq;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (rx_irq === 1'b1) begin
            rx_cnt++;
            t_rirq = $time;
        end
        if (tx_irq === 1'b1) begin
            tx_cnt++;
            t_tirq = $time;
        end
    end
    upec_channel i_dut (.i_ref_clk(clk), .i_srst(srst), .i_avs_address(adr),
        .i_avs_byteenable(4'hf), .i_avs_read(rd_s), .i_avs_write(wr_s),
        .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_r),
        .i_baud_tick(baud), .i_timer_tick(1'b0), .i_rx_line(rx_line),
        .i_clear_to_send_n(cts_n), .i_shift_clock_pin(1'b1), .o_shift_clock_pin(sck),
        .o_shift_clock_oe(sck_oe), .o_tx_line(tx_line), .o_rx_interrupt(rx_irq),
        .o_tx_interrupt(tx_irq));
    upec_peer i_peer (.i_clk(clk), .i_sck(sck), .i_tx_line(tx_line), .o_rx_line(rx_line));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge clk);
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        rd_s <= ~w;
        wr_s <= w;
        @(posedge clk);
        while (wait_r !== 1'b0) @(posedge clk);
        v = rdat;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [7:0] e, input string nm);
        bus(1'b0, idx, 8'h00);
        check(nm, v, {24'h0, e});
    endtask
    task automatic rxf(input logic [8:0] b, input int n, input logic stop, input int idx);
        int c;
        c = rx_cnt;
        i_peer.send(b, n, stop);
        check("rx irq count", 32'(rx_cnt - c), (idx < 0) ? 32'h0 : 32'h1);
        if (idx >= 0) check("rx irq bit", 32'((t_rirq - i_peer.t_rx) / 800), idx);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end
    initial begin
        int c;
        int k;
        logic p;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rdc(`UPEC_IDX_MODE, 8'h00, "mode reset");
        rdc(`UPEC_IDX_CTRL, 8'h00, "ctrl reset");
        rdc(10'h000, 8'h00, "unmapped");
        bus(1'b1, `UPEC_IDX_MODE, 8'hff);
        rdc(`UPEC_IDX_MODE, 8'hff, "mode rw");
        bus(1'b1, `UPEC_IDX_CTRL, 8'hff);
        rdc(`UPEC_IDX_CTRL, 8'h63, "ctrl ro");
        for (int f = 1; f <= 2; f++) begin
            for (int e = 0; e <= 1; e++) begin
                bus(1'b1, `UPEC_IDX_MODE, {4'h0, 2'(f), 2'b10});
                bus(1'b1, `UPEC_IDX_CTRL, {1'b0, 1'(e), 6'h20});
                c = tx_cnt;
                bus(1'b1, `UPEC_IDX_BUF, 8'h4b);
                // Both data widths of 8'h4b hold four ones, so parity is the sense inverted
                p = ~1'(e);
                i_peer.grab(f + 7, got);
                check("tx frame", got, (f == 1) ? {2'b01, p, 7'h4b} : {1'b1, p, 8'h4b});
                check("tx irq count", 32'(tx_cnt - c), 1);
                k = int'((t_tirq - i_peer.t_tx) / 50) - (f + 8) * 16;
                check("tx irq place", 32'(k >= -2 && k <= 2), 1);
                repeat (20) @(posedge clk);
            end
        end
        bus(1'b1, `UPEC_IDX_MODE, 8'h4a);
        bus(1'b1, `UPEC_IDX_CTRL, 8'h00);
        cts_n <= 1'b1;
        c = tx_cnt;
        bus(1'b1, `UPEC_IDX_BUF, 8'h5a);
        repeat (60) @(posedge clk);
        check("cts hold line", {31'h0, tx_line}, 32'h1);
        cts_n <= 1'b0;
        i_peer.grab(8, got);
        check("cts frame", got, 10'h15a);
        check("cts tx irq", 32'(tx_cnt - c), 1);
        bus(1'b1, `UPEC_IDX_MODE, 8'h26);
        bus(1'b1, `UPEC_IDX_CTRL, 8'h60);
        rxf(9'h035, 8, 1'b1, 9);
        rdc(`UPEC_IDX_BUF, 8'h35, "rx even ok");
        rdc(`UPEC_IDX_CTRL, 8'h60, "no parity flag");
        rxf(9'h0b5, 8, 1'b1, 9);
        rdc(`UPEC_IDX_BUF, 8'hb5, "rx even bad");
        rdc(`UPEC_IDX_CTRL, 8'h68, "parity flag 7");
        rdc(`UPEC_IDX_CTRL, 8'h60, "flag cleared");
        bus(1'b1, `UPEC_IDX_MODE, 8'h2a);
        bus(1'b1, `UPEC_IDX_CTRL, 8'h20);
        rxf(9'h10f, 9, 1'b1, 9);
        rdc(`UPEC_IDX_BUF, 8'h0f, "rx odd ok");
        rdc(`UPEC_IDX_CTRL, 8'ha0, "odd ninth ok");
        rxf(9'h00f, 9, 1'b1, 9);
        rdc(`UPEC_IDX_BUF, 8'h0f, "rx odd bad");
        rdc(`UPEC_IDX_CTRL, 8'h28, "parity flag 8");
        bus(1'b1, `UPEC_IDX_MODE, 8'h2e);
        bus(1'b1, `UPEC_IDX_CTRL, 8'h00);
        rxf(9'h111, 9, 1'b1, 9);
        rdc(`UPEC_IDX_CTRL, 8'h80, "ninth read only");
        rxf(9'h122, 9, 1'b1, 9);
        rdc(`UPEC_IDX_CTRL, 8'h90, "overrun flag");
        rdc(`UPEC_IDX_BUF, 8'h11, "kept word");
        bus(1'b1, `UPEC_IDX_MODE, 8'h0e);
        rxf(9'h1aa, 9, 1'b1, -1);
        rdc(`UPEC_IDX_CTRL, 8'h80, "flags after pause");
        bus(1'b1, `UPEC_IDX_MODE, 8'h3e);
        rxf(9'h033, 9, 1'b1, -1);
        bus(1'b0, `UPEC_IDX_BUF, 8'h00);
        rxf(9'h144, 9, 1'b1, 9);
        rdc(`UPEC_IDX_BUF, 8'h44, "wake word");
        bus(1'b1, `UPEC_IDX_MODE, 8'h26);
        rxf(9'h055, 7, 1'b0, 8);
        rdc(`UPEC_IDX_CTRL, 8'h84, "framing flag");
        // Shift mode, clock driven from baud ticks on every cycle
        bus(1'b1, `UPEC_IDX_MODE, 8'h00);
        baud <= 1'b1;
        c = i_peer.n_sck;
        k = tx_cnt;
        bus(1'b1, `UPEC_IDX_BUF, 8'h4b);
        repeat (40) @(posedge clk);
        check("shift pulses", 32'(i_peer.n_sck - c), 8);
        check("shift data", {24'h0, i_peer.sr}, 32'h4b);
        check("shift tx irq", 32'(tx_cnt - k), 1);
        check("clock drive", {31'h0, sck_oe}, 32'h1);
        bus(1'b1, `UPEC_IDX_MODE, 8'h20);
        c = rx_cnt;
        rdc(`UPEC_IDX_BUF, 8'h55, "framing word");
        repeat (40) @(posedge clk);
        check("shift rx irq", 32'(rx_cnt - c), 1);
        rdc(`UPEC_IDX_BUF, 8'hff, "shift rx word");
        results();
    end
endmodule
